// File: hw/reg_seq_pkg.sv
// shared constants for the regulator enable, soft-start and fault sequencer
// assumes a 10 MHz core clock; variant codes are plain integers of the build option
package reg_seq_pkg;
   localparam int unsigned CLK_HZ          = 10000000;
   // variant codes
   localparam logic [7:0] VAR_00  = 8'h00;
   localparam logic [7:0] VAR_01  = 8'h01;
   localparam logic [7:0] VAR_03  = 8'h03;
   localparam logic [7:0] VAR_04  = 8'h04;
   localparam logic [7:0] VAR_05  = 8'h05;
   localparam logic [7:0] VAR_042 = 8'h2a;
   localparam logic [7:0] VAR_24  = 8'h18;
   localparam logic [7:0] VAR_79  = 8'h4f;
   // field positions and reset values
   localparam int unsigned SETPT_W        = 8;
   localparam int unsigned MODE_BIT       = 7;
   localparam logic [7:0]  SETPT0_RST     = 8'h00;
   localparam logic [7:0]  SETPT1_RST     = 8'h00;
   localparam logic [1:0]  EN_BITS_RST_ON = 2'h3;
   localparam logic [1:0]  EN_BITS_RST_10 = 2'h1;
   localparam logic        BLEED_RST      = 1'b0;
   // current limit, retry and soft-start timing, reference width
   localparam int unsigned ILIM_CYCLES    = 16;
   localparam int unsigned RETRY_MS       = 1700;
   localparam int unsigned RETRY_CYC      = RETRY_MS * (CLK_HZ / 1000);
   localparam int unsigned SS_US          = 200;
   localparam int unsigned SS_CYC         = SS_US * (CLK_HZ / 1000000);
   localparam int unsigned REF_W          = 8;
endpackage

// File: hw/pin_sync3.sv
// three-stage pin synchroniser with agreement filter
// assumes an asynchronous pin input; output changes once stages two and three agree
`timescale 1ns/100ps
module pin_sync3 (
   input  wire logic core_clk,
   input  wire logic sys_rst,
   input  wire logic clk_en,
   input  wire logic pin_in,
   output logic      pin_out
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   // stage one feeds only stage two, so metastability never reaches the filter
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_q    <= 1'b0;
         s2_q    <= 1'b0;
         s3_q    <= 1'b0;
         pin_out <= 1'b0;
      end else if (clk_en) begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) pin_out <= s3_q;
      end
   end
endmodule // pin_sync3

// File: hw/regulator_enable_fault_control.sv
// enable, soft-start, bleed and current-limit retry control of a step-down regulator
// assumes register writes arrive as single-cycle strobes from a serial front end on core_clk;
// enable and select pins are asynchronous and are synchronised here
`timescale 1ns/100ps
// Functional notes
// - enable pin low holds converter off, all circuitry off, ignoring select and bits
// - enable pin low blocks register writes and register read answers
// - other variants keep register contents while enable pin is low
// - variants 04, 24, 042, 79 reload defaults while enable pin is low
// - power-on reset loads every register with defaults
// - bleed bit high and enable pin or selected bit low connects discharge load
// - rising enable pin with selected bit high starts converter and soft-start
// - soft-start ramps reference slowly; synchronous rectifier off until done
// - 16 consecutive limit cycles: shut down, output stage high-z, retry after 1700 ms
// - variants 00,04,08,09,23,24,42,79: both enable bits reset high
// - variants 01 and 05: enable bits reset to pattern 10
// - variant 03 forces internal select low
// - enable high: output on exactly when the selected enable bit is high
// - mode bit of active setpoint high forces fixed-frequency switching
// - select low picks setpoint register 0, high picks setpoint register 1
module regulator_enable_fault_control #(
   parameter logic [7:0]  VARIANT     = reg_seq_pkg::VAR_00,
   parameter int unsigned RETRY_COUNT = reg_seq_pkg::RETRY_CYC
) (
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic       clk_en,
   input  wire logic       enable_pin,
   input  wire logic       setpoint_select_pin,
   input  wire logic       wr_setpt0,
   input  wire logic       wr_setpt1,
   input  wire logic       wr_ctrl,
   input  wire logic [7:0] wr_data,
   input  wire logic       rd_req,
   input  wire logic [1:0] rd_sel,
   input  wire logic       sw_cycle_end,
   input  wire logic       sw_cycle_ilim,
   output logic            rd_valid,
   output logic [7:0]      rd_data,
   output logic            converter_on,
   output logic            circuits_on,
   output logic            soft_start,
   output logic [7:0]      ref_level,
   output logic            sync_rect_en,
   output logic            output_hiz,
   output logic            bleed_on,
   output logic            pfm_allowed,
   output logic [5:0]      active_setpoint,
   output logic            fault_wait
);
   typedef enum logic [3:0] {
      ST_OFF   = 4'b0001,
      ST_SOFT  = 4'b0010,
      ST_RUN   = 4'b0100,
      ST_RETRY = 4'b1000
   } seq_state_t;

   seq_state_t  state_q, state_d;
   logic [7:0]  setpoint_register_0, setpoint_register_1;
   logic        converter_on_bit_low_sel, converter_on_bit_high_sel, bleed_bit_q;
   logic [4:0]  ilim_cnt_q;
   logic [31:0] wait_cnt_q;
   logic        en_s, sel_s, en_prev_q;

   function automatic logic [1:0] en_bits_default(input logic [7:0] v);
      // only the host-powering builds come up with the high-select bit clear
      en_bits_default = (v == reg_seq_pkg::VAR_01 || v == reg_seq_pkg::VAR_05)
                        ? reg_seq_pkg::EN_BITS_RST_10
                        : reg_seq_pkg::EN_BITS_RST_ON;
   endfunction

   pin_sync3 u_en  (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
                    .pin_in(enable_pin), .pin_out(en_s));
   pin_sync3 u_sel (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
                    .pin_in(setpoint_select_pin), .pin_out(sel_s));

   // selection and decode
   localparam logic [1:0] EN_RST = en_bits_default(VARIANT);
   wire clear_on_low = (VARIANT == reg_seq_pkg::VAR_04) || (VARIANT == reg_seq_pkg::VAR_24) ||
                       (VARIANT == reg_seq_pkg::VAR_042) || (VARIANT == reg_seq_pkg::VAR_79);
   wire sel_int      = (VARIANT == reg_seq_pkg::VAR_03) ? 1'b0 : sel_s;
   wire sel_bit      = sel_int ? converter_on_bit_high_sel : converter_on_bit_low_sel;
   wire [7:0] act_sp = sel_int ? setpoint_register_1 : setpoint_register_0;
   wire want_on      = en_s && sel_bit;
   wire en_rise      = en_s && !en_prev_q;
   wire ilim_trip    = sw_cycle_end && sw_cycle_ilim &&
                       (ilim_cnt_q == 5'(reg_seq_pkg::ILIM_CYCLES - 1));
   // ramp restarts from zero on every entry, whatever the counter held in the state before
   wire [31:0] ramp_cnt = (state_q == ST_SOFT) ? (wait_cnt_q + 32'h1) : 32'h0;
   wire ss_done      = (wait_cnt_q >= 32'(reg_seq_pkg::SS_CYC - 1));
   wire retry_done   = (wait_cnt_q >= 32'(RETRY_COUNT - 1));

   // next state of the sequencer
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_OFF:   if (want_on && (en_rise || en_prev_q)) state_d = ST_SOFT;
         ST_SOFT:  if (!want_on) state_d = ST_OFF;
                   else if (ilim_trip) state_d = ST_RETRY;
                   else if (ss_done) state_d = ST_RUN;
         ST_RUN:   if (!want_on) state_d = ST_OFF;
                   else if (ilim_trip) state_d = ST_RETRY;
         ST_RETRY: if (!want_on) state_d = ST_OFF;
                   else if (retry_done) state_d = ST_SOFT;
         default:  state_d = ST_OFF;
      endcase
   end

   // registers: reset to defaults, cleared while pin low on some variants, writes blocked
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         setpoint_register_0       <= reg_seq_pkg::SETPT0_RST;
         setpoint_register_1       <= reg_seq_pkg::SETPT1_RST;
         converter_on_bit_low_sel  <= EN_RST[0];
         converter_on_bit_high_sel <= EN_RST[1];
         bleed_bit_q               <= reg_seq_pkg::BLEED_RST;
      end else if (clk_en) begin
         if (!en_s && clear_on_low) begin
            setpoint_register_0       <= reg_seq_pkg::SETPT0_RST;
            setpoint_register_1       <= reg_seq_pkg::SETPT1_RST;
            converter_on_bit_low_sel  <= EN_RST[0];
            converter_on_bit_high_sel <= EN_RST[1];
            bleed_bit_q               <= reg_seq_pkg::BLEED_RST;
         end else if (en_s) begin
            if (wr_setpt0) setpoint_register_0 <= wr_data;
            if (wr_setpt1) setpoint_register_1 <= wr_data;
            if (wr_ctrl) begin
               converter_on_bit_low_sel  <= wr_data[0];
               converter_on_bit_high_sel <= wr_data[1];
               bleed_bit_q               <= wr_data[2];
            end
         end
      end
   end

   // sequencer, counters and registered outputs
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q         <= ST_OFF;
         en_prev_q       <= 1'b0;
         ilim_cnt_q      <= 5'h00;
         wait_cnt_q      <= 32'h0;
         rd_valid        <= 1'b0;
         rd_data         <= 8'h00;
         converter_on    <= 1'b0;
         circuits_on     <= 1'b0;
         soft_start      <= 1'b0;
         ref_level       <= 8'h00;
         sync_rect_en    <= 1'b0;
         output_hiz      <= 1'b1; // output stage floats until a start is granted
         bleed_on        <= 1'b0;
         pfm_allowed     <= 1'b0;
         active_setpoint <= 6'h00;
         fault_wait      <= 1'b0;
      end else if (clk_en) begin
         state_q   <= state_d;
         en_prev_q <= en_s;
         // counter clears on a clean cycle, when off, and on entry to soft-start
         if (state_d == ST_OFF || state_d == ST_RETRY || (state_d == ST_SOFT && state_q != ST_SOFT))
            ilim_cnt_q <= 5'h00;
         else if (sw_cycle_end) ilim_cnt_q <= sw_cycle_ilim ? ilim_cnt_q + 5'h01 : 5'h00;
         wait_cnt_q <= (state_d != state_q) ? 32'h0 : wait_cnt_q + 32'h1;
         // read answers only while the enable pin is high
         rd_valid <= rd_req && en_s;
         rd_data  <= !(rd_req && en_s) ? 8'h00 : (rd_sel == 2'h0) ? setpoint_register_0 :
                     (rd_sel == 2'h1) ? setpoint_register_1 :
                     {5'h00, bleed_bit_q, converter_on_bit_high_sel, converter_on_bit_low_sel};
         converter_on <= (state_d == ST_SOFT) || (state_d == ST_RUN);
         circuits_on  <= en_s;
         soft_start   <= (state_d == ST_SOFT);
         // reference ramps linearly across the soft-start window
         ref_level    <= (state_d == ST_RUN) ? 8'hff : (state_d == ST_SOFT) ?
                         8'((ramp_cnt * 32'd255) / 32'(reg_seq_pkg::SS_CYC)) : 8'h00;
         sync_rect_en <= (state_d == ST_RUN);
         output_hiz   <= !((state_d == ST_SOFT) || (state_d == ST_RUN));
         bleed_on     <= bleed_bit_q && (!en_s || !sel_bit);
         pfm_allowed  <= (state_d == ST_RUN) && !act_sp[reg_seq_pkg::MODE_BIT];
         active_setpoint <= act_sp[5:0];
         fault_wait   <= (state_d == ST_RETRY);
      end
   end

   // one cycle after the trip into the retry wait the output floats and the wait flag rises, both together
   AST_RETRY_HIZ: assert property (@(posedge core_clk) disable iff (sys_rst)
      (clk_en && state_q != ST_RETRY && state_d == ST_RETRY) |=> output_hiz && fault_wait)
      else $error("fault trip did not tristate output");
   AST_EN_LOW_OFF: assert property (@(posedge core_clk) disable iff (sys_rst)
      (clk_en && !en_s) |=> !converter_on && !circuits_on)
      else $error("converter on with enable low");
   AST_NO_READ_LOW: assert property (@(posedge core_clk) disable iff (sys_rst)
      (clk_en && !en_s) |=> !rd_valid) else $error("read answered with enable low");
   AST_SS_NO_SR: assert property (@(posedge core_clk) disable iff (sys_rst)
      soft_start |-> !sync_rect_en) else $error("rectifier on during soft-start");
   AST_BLEED: assert property (@(posedge core_clk) disable iff (sys_rst)
      (clk_en && bleed_bit_q && !en_s) |=> bleed_on) else $error("bleed load missing");
   AST_MODE: assert property (@(posedge core_clk) disable iff (sys_rst)
      (clk_en && act_sp[reg_seq_pkg::MODE_BIT]) |=> !pfm_allowed) else $error("pfm with mode set");
   AST_SEL_FORCE: assert property (@(posedge core_clk) disable iff (sys_rst)
      (VARIANT == reg_seq_pkg::VAR_03) |-> (act_sp == setpoint_register_0))
      else $error("select not forced low");
   AST_CNT_CLEAR: assert property (@(posedge core_clk) disable iff (sys_rst)
      (clk_en && state_q == ST_RUN && state_d == ST_RUN && sw_cycle_end && !sw_cycle_ilim)
      |=> ilim_cnt_q == 5'h00) else $error("limit counter not cleared");
   // enable pin and selected bit both high out of the off state begin a ramp at once
   AST_SOFT_START: assert property (@(posedge core_clk) disable iff (sys_rst)
      (clk_en && state_q == ST_OFF && want_on) |=> soft_start && converter_on && !output_hiz)
      else $error("soft-start did not begin");
   AST_SEL_OUTPUT: assert property (@(posedge core_clk) disable iff (sys_rst)
      (clk_en && en_s && !sel_bit) |=> !converter_on && !soft_start)
      else $error("output on with selected bit low");
   // keeping builds must neither lose nor take a value while the pin is low
   AST_HOLD_LOW: assert property (@(posedge core_clk) disable iff (sys_rst)
      (clk_en && !en_s && !clear_on_low)
      |=> $stable(setpoint_register_0) && $stable(setpoint_register_1) && $stable(bleed_bit_q))
      else $error("register changed with enable low");
   AST_CLEAR_LOW: assert property (@(posedge core_clk) disable iff (sys_rst)
      (clk_en && !en_s && clear_on_low)
      |=> setpoint_register_0 == reg_seq_pkg::SETPT0_RST && bleed_bit_q == reg_seq_pkg::BLEED_RST
          && {converter_on_bit_high_sel, converter_on_bit_low_sel} == EN_RST)
      else $error("registers not reloaded with enable low");
   // the retry wait has run out with the converter still wanted
   sequence retry_expiry;
      clk_en && state_q == ST_RETRY && want_on && retry_done;
   endsequence
   AST_RETRY_RESTART: assert property (@(posedge core_clk) disable iff (sys_rst)
      retry_expiry |=> soft_start && !fault_wait && !output_hiz)
      else $error("no soft-start after retry wait");
endmodule // regulator_enable_fault_control

// File: verification/host_model.sv
// host-side model: drives the enable and select pins and the register strobes
// assumes the bench calls its tasks from a single process
`timescale 1ns/100ps
module host_model (
   input  wire logic       core_clk,
   input  wire logic       rd_valid,
   input  wire logic [7:0] rd_data,
   output logic            enable_pin,
   output logic            setpoint_select_pin,
   output logic            wr_setpt0,
   output logic            wr_setpt1,
   output logic            wr_ctrl,
   output logic [7:0]      wr_data,
   output logic            rd_req,
   output logic [1:0]      rd_sel
);
   // select held low from power-on so a supplied processor keeps running
   initial begin
      {enable_pin, setpoint_select_pin} = 2'h0;
      {wr_setpt0, wr_setpt1, wr_ctrl, rd_req} = 4'h0;
      wr_data = 8'h00;
      rd_sel = 2'h0;
   end
   // pins move just after an edge, like every other request
   task automatic pins(input logic en, input logic sel);
      @(posedge core_clk) #1;
      enable_pin = en;
      setpoint_select_pin = sel;
   endtask
   // one-cycle strobe; data inverted after release so stale values never look valid
   task automatic wr(input logic [1:0] kind, input logic [7:0] d);
      @(posedge core_clk) #1;
      wr_data = d;
      {wr_ctrl, wr_setpt1, wr_setpt0} = 3'h1 << kind;
      @(posedge core_clk) #1;
      {wr_ctrl, wr_setpt1, wr_setpt0} = 3'h0;
      wr_data = ~d;
   endtask
   // answer stands one cycle after the strobe edge, taken in that cycle
   task automatic rd(input logic [1:0] s, output logic v, output logic [7:0] d);
      @(posedge core_clk) #1;
      rd_sel = s;
      rd_req = 1'b1;
      @(posedge core_clk) #1;
      rd_req = 1'b0;
      rd_sel = ~s;
      v = rd_valid;
      d = rd_data;
   endtask
endmodule // host_model

// File: verification/tb_regulator_enable_fault_control.sv
// self-checking bench for the enable, soft-start and fault sequencer
// assumes variant 00 for the main build, three side builds on shared inputs, short retry count
`timescale 1ns/100ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
   $display("wrong value at %0t: %h expected %h", $time, (a), (e)); end end
module tb_regulator_enable_fault_control;
   localparam int unsigned RETRY = 50;
   localparam int unsigned SS = reg_seq_pkg::SS_CYC;
   logic core_clk, sys_rst, clk_en, sw_cycle_end, sw_cycle_ilim, v;
   logic enable_pin, setpoint_select_pin, wr_setpt0, wr_setpt1, wr_ctrl, rd_req;
   logic rd_valid, converter_on, circuits_on, soft_start, sync_rect_en;
   logic output_hiz, bleed_on, pfm_allowed, fault_wait;
   logic [7:0] wr_data, rd_data, ref_level, d, r_mid;
   logic [5:0] active_setpoint;
   logic [1:0] rd_sel;
   logic [7:0] rd_data_clr, rd_data_pat;
   logic [5:0] sp_fix;
   int err_count, checked, cycles;
   regulator_enable_fault_control #(.VARIANT(reg_seq_pkg::VAR_00), .RETRY_COUNT(RETRY))
   u_regulator_enable_fault_control (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .enable_pin(enable_pin), .setpoint_select_pin(setpoint_select_pin),
      .wr_setpt0(wr_setpt0), .wr_setpt1(wr_setpt1), .wr_ctrl(wr_ctrl), .wr_data(wr_data),
      .rd_req(rd_req), .rd_sel(rd_sel), .sw_cycle_end(sw_cycle_end),
      .sw_cycle_ilim(sw_cycle_ilim), .rd_valid(rd_valid), .rd_data(rd_data),
      .converter_on(converter_on), .circuits_on(circuits_on), .soft_start(soft_start),
      .ref_level(ref_level), .sync_rect_en(sync_rect_en), .output_hiz(output_hiz),
      .bleed_on(bleed_on), .pfm_allowed(pfm_allowed), .active_setpoint(active_setpoint),
      .fault_wait(fault_wait));
   // clearing, host-powering and fixed-select builds see the same pins and strobes
   regulator_enable_fault_control #(.VARIANT(reg_seq_pkg::VAR_04), .RETRY_COUNT(RETRY))
   u_regulator_enable_fault_control_clr (.core_clk(core_clk), .sys_rst(sys_rst),
      .clk_en(clk_en), .enable_pin(enable_pin), .setpoint_select_pin(setpoint_select_pin),
      .wr_setpt0(wr_setpt0), .wr_setpt1(wr_setpt1), .wr_ctrl(wr_ctrl), .wr_data(wr_data),
      .rd_req(rd_req), .rd_sel(rd_sel), .sw_cycle_end(sw_cycle_end),
      .sw_cycle_ilim(sw_cycle_ilim), .rd_valid(), .rd_data(rd_data_clr), .converter_on(),
      .circuits_on(), .soft_start(), .ref_level(), .sync_rect_en(), .output_hiz(),
      .bleed_on(), .pfm_allowed(), .active_setpoint(), .fault_wait());
   regulator_enable_fault_control #(.VARIANT(reg_seq_pkg::VAR_05), .RETRY_COUNT(RETRY))
   u_regulator_enable_fault_control_pat (.core_clk(core_clk), .sys_rst(sys_rst),
      .clk_en(clk_en), .enable_pin(enable_pin), .setpoint_select_pin(setpoint_select_pin),
      .wr_setpt0(wr_setpt0), .wr_setpt1(wr_setpt1), .wr_ctrl(wr_ctrl), .wr_data(wr_data),
      .rd_req(rd_req), .rd_sel(rd_sel), .sw_cycle_end(sw_cycle_end),
      .sw_cycle_ilim(sw_cycle_ilim), .rd_valid(), .rd_data(rd_data_pat), .converter_on(),
      .circuits_on(), .soft_start(), .ref_level(), .sync_rect_en(), .output_hiz(),
      .bleed_on(), .pfm_allowed(), .active_setpoint(), .fault_wait());
   regulator_enable_fault_control #(.VARIANT(reg_seq_pkg::VAR_03), .RETRY_COUNT(RETRY))
   u_regulator_enable_fault_control_fix (.core_clk(core_clk), .sys_rst(sys_rst),
      .clk_en(clk_en), .enable_pin(enable_pin), .setpoint_select_pin(setpoint_select_pin),
      .wr_setpt0(wr_setpt0), .wr_setpt1(wr_setpt1), .wr_ctrl(wr_ctrl), .wr_data(wr_data),
      .rd_req(rd_req), .rd_sel(rd_sel), .sw_cycle_end(sw_cycle_end),
      .sw_cycle_ilim(sw_cycle_ilim), .rd_valid(), .rd_data(), .converter_on(),
      .circuits_on(), .soft_start(), .ref_level(), .sync_rect_en(), .output_hiz(),
      .bleed_on(), .pfm_allowed(), .active_setpoint(sp_fix), .fault_wait());
   host_model u_host_model (.core_clk(core_clk), .rd_valid(rd_valid), .rd_data(rd_data),
      .enable_pin(enable_pin), .setpoint_select_pin(setpoint_select_pin),
      .wr_setpt0(wr_setpt0), .wr_setpt1(wr_setpt1), .wr_ctrl(wr_ctrl), .wr_data(wr_data),
      .rd_req(rd_req), .rd_sel(rd_sel));
   // waits land two steps past the edge so registered outputs have settled
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #2;
   endtask
   // one switching cycle end, flagged as limited or clean
   task automatic sw(input logic lim);
      @(posedge core_clk) #1;
      sw_cycle_end = 1'b1;
      sw_cycle_ilim = lim;
      @(posedge core_clk) #1;
      sw_cycle_end = 1'b0;
      sw_cycle_ilim = 1'b0;
   endtask
   // defaults after power-on, then the first start with its ramp
   task automatic t_start();
      u_host_model.pins(1'b1, 1'b0);
      cyc(8);
      `CHK(soft_start, 1'b1)
      `CHK(sync_rect_en, 1'b0)
      u_host_model.rd(2'h2, v, d);
      `CHK({v, d[2:0]}, 4'hb)
      `CHK(rd_data_pat[2:0], 3'h1)
      u_host_model.rd(2'h0, v, d);
      `CHK(d, reg_seq_pkg::SETPT0_RST)
      cyc(SS / 2);
      r_mid = ref_level;
      cyc(SS / 2 + 8);
      `CHK(r_mid < ref_level, 1'b1)
      `CHK({soft_start, sync_rect_en, converter_on}, 3'h3)
   endtask
   // setpoint choice by pin, mode bit of the chosen one
   task automatic t_select();
      u_host_model.wr(2'h1, 8'h85);
      u_host_model.wr(2'h0, 8'h0a);
      u_host_model.pins(1'b1, 1'b1);
      cyc(8);
      `CHK({active_setpoint, pfm_allowed}, 7'h0a)
      `CHK(sp_fix, 6'h0a)
      u_host_model.pins(1'b1, 1'b0);
      cyc(8);
      `CHK({active_setpoint, pfm_allowed}, 7'h15)
   endtask
   // software enable per select, bleed, then enable pin low with access blocked
   task automatic t_enable();
      u_host_model.wr(2'h2, 8'h06);
      cyc(8);
      `CHK({converter_on, bleed_on}, 2'h1)
      u_host_model.pins(1'b1, 1'b1);
      cyc(8);
      `CHK({converter_on, bleed_on}, 2'h2)
      u_host_model.pins(1'b0, 1'b1);
      cyc(8);
      `CHK({converter_on, circuits_on, bleed_on}, 3'h1)
      u_host_model.rd(2'h2, v, d);
      `CHK(v, 1'b0)
      u_host_model.wr(2'h2, 8'h00);
      u_host_model.pins(1'b1, 1'b1);
      cyc(8);
      `CHK(soft_start, 1'b1)
      u_host_model.rd(2'h2, v, d);
      `CHK({v, d[2:0]}, 4'he)
      `CHK(rd_data_clr[2:0], 3'h3)
      u_host_model.rd(2'h1, v, d);
      `CHK(d, 8'h85)
      `CHK(rd_data_clr, reg_seq_pkg::SETPT1_RST)
      cyc(SS + 8);
   endtask
   // a clean cycle breaks the run; sixteen in a row trip, then timed retry
   task automatic t_fault();
      repeat (15) sw(1'b1);
      sw(1'b0);
      repeat (15) sw(1'b1);
      cyc(3);
      `CHK(fault_wait, 1'b0)
      sw(1'b1);
      cyc(3);
      `CHK({fault_wait, output_hiz, converter_on}, 3'h6)
      cyc(RETRY + 5);
      `CHK({fault_wait, soft_start}, 2'h1)
   endtask
   task automatic end_sim();
      if (err_count == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   // a hang past nearly three times the expected run is counted and closes the run
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 12000) begin
         err_count++;
         end_sim();
      end
   end
   initial begin
      {sys_rst, clk_en, sw_cycle_end, sw_cycle_ilim} = 4'hc;
      repeat (5) @(posedge core_clk);
      #1 sys_rst = 1'b0;
      t_start();
      t_select();
      t_enable();
      t_fault();
      end_sim();
   end
endmodule // tb_regulator_enable_fault_control
